/* File: wdog_pkg.sv */
// Constants and types shared by the reset and watchdog block
package wdog_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int LPO_PERIOD_US = 1000;
  localparam int LPO_DIV_CYC = (CLK_HZ / 1_000_000) * LPO_PERIOD_US;
  localparam int RST_HOLD_CYC = 16;

  localparam logic [15:0] RCR_ADDR = 16'h1800;
  localparam logic [15:0] SYSTEM_OPTIONS_ONE_ADDR = 16'h1802;
  localparam logic [15:0] SYSTEM_OPTIONS_TWO_ADDR = 16'h1803;
  localparam logic [15:0] UNIMP_LO = 16'h1900;
  localparam logic [15:0] UNIMP_HI = 16'h7FFF;

  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
  localparam logic [15:0] SP_RESET = 16'h00FF;

  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Cause bit positions in reset_cause_register
  localparam int CAUSE_POR = 7;
  localparam int CAUSE_PIN = 6;
  localparam int CAUSE_WDOG = 5;
  localparam int CAUSE_ILLEGAL_OPCODE_RESET = 4;
  localparam int CAUSE_ILLEGAL_ADDRESS_RESET = 3;
  localparam int CAUSE_LVD = 1;

  // Option field positions and reset defaults
  localparam int TSEL_POS = 6;
  localparam int CLKS_POS = 7;
  localparam int WIN_POS = 6;
  localparam logic [1:0] TSEL_RESET = 2'h3;
  localparam logic CLKS_RESET = 1'b0;
  localparam logic WIN_RESET = 1'b0;

  // Timeout and window counts
  localparam logic [18:0] LPO_TO_1 = 19'h0_0020;
  localparam logic [18:0] LPO_TO_2 = 19'h0_0100;
  localparam logic [18:0] LPO_TO_3 = 19'h0_0400;
  localparam logic [18:0] BUS_TO_1 = 19'h0_2000;
  localparam logic [18:0] BUS_TO_2 = 19'h1_0000;
  localparam logic [18:0] BUS_TO_3 = 19'h4_0000;
  localparam logic [18:0] WIN_OPEN_1 = 19'h0_1800;
  localparam logic [18:0] WIN_OPEN_2 = 19'h0_C000;
  localparam logic [18:0] WIN_OPEN_3 = 19'h3_0000;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_FETCH_HI = 2'b01,
    ST_FETCH_LO = 2'b11,
    ST_RUN = 2'b10
  } rst_state_e;
endpackage

/* File: reset_sources_and_watchdog.sv */
// Reset sequencer, reset cause capture and operating watchdog
`timescale 1ns/10ps
`default_nettype none

module reset_sources_and_watchdog #(
  parameter int LPO_DIV = wdog_pkg::LPO_DIV_CYC,
  parameter int HOLD_CYC = wdog_pkg::RST_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire wdog_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic pin_reset_n,
  input wire logic lvd_req,
  input wire logic illegal_opcode,
  input wire logic debug_force_reset,
  input wire logic bdm_mode,
  input wire logic stop_mode,
  input wire logic imask_clear,
  output logic vec_rd,
  output logic [15:0] vec_addr,
  input wire logic [7:0] vec_rdata,
  output logic [15:0] pc_init,
  output logic [15:0] stack_pointer,
  output logic imask,
  output logic sys_reset_n,
  output logic cpu_run,
  output logic periph_disable,
  output logic pins_force_input
);
  import wdog_pkg::*;

  // Timeout length for a clock source and select value
  function automatic logic [18:0] wd_limit(input logic clks,
                                           input logic [1:0] tsel);
    logic [18:0] v;
    v = BUS_TO_3;
    unique case ({clks, tsel})
      3'b001: v = LPO_TO_1;
      3'b010: v = LPO_TO_2;
      3'b011: v = LPO_TO_3;
      3'b101: v = BUS_TO_1;
      3'b110: v = BUS_TO_2;
      3'b111: v = BUS_TO_3;
      default: v = BUS_TO_3;
    endcase
    return v;
  endfunction

  // Least count before a windowed service is allowed
  function automatic logic [18:0] wd_open(input logic [1:0] tsel);
    logic [18:0] v;
    v = WIN_OPEN_3;
    unique case (tsel)
      2'b01: v = WIN_OPEN_1;
      2'b10: v = WIN_OPEN_2;
      2'b11: v = WIN_OPEN_3;
      default: v = WIN_OPEN_3;
    endcase
    return v;
  endfunction

  rst_state_e state_r;
  logic [15:0] hold_cnt_r;
  logic [7:0] cause_r;
  logic [7:0] vec_hi_r;
  logic [1:0] pin_sync_r;
  logic [1:0] lvd_sync_r;
  logic [15:0] lpo_cnt_r;
  logic lpo_tick_r;
  logic [18:0] wd_cnt_r;
  logic wd_armed_r;
  logic [1:0] tsel_r;
  logic clks_r;
  logic win_r;
  logic opt1_lock_r;
  logic opt2_lock_r;
  logic fetch_lo_data_r;

  logic run;
  logic ext_hold;
  logic rcr_wr;
  logic key_ok;
  logic wd_en;
  logic win_act;
  logic wd_inc;
  logic wd_freeze;
  logic wd_timeout;
  logic wd_badkey;
  logic wd_early;
  logic illegal_address_reset;
  logic wd_reset;
  logic rst_req;
  logic [7:0] cause_nxt;

  // Pin and low-voltage requests pass two flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_sync_r <= 2'h0;
      lvd_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], ~pin_reset_n};
      lvd_sync_r <= {lvd_sync_r[0], lvd_req};
    end
  end

  // Decode of reset requests
  always_comb begin
    run = (state_r == ST_RUN);
    ext_hold = pin_sync_r[1] | lvd_sync_r[1];
    rcr_wr = run & reg_req.wr & (reg_req.addr == RCR_ADDR);
    key_ok = (reg_req.wdata == KEY_FIRST) |
             (reg_req.wdata == KEY_SECOND);
    wd_en = (tsel_r != 2'h0);
    win_act = wd_en & clks_r & win_r;
    wd_freeze = bdm_mode | stop_mode;
    wd_inc = run & wd_en & ~wd_freeze &
             (clks_r | lpo_tick_r);
    wd_timeout = wd_inc &
      (wd_cnt_r == wd_limit(clks_r, tsel_r) - 19'h0_0001);
    wd_badkey = rcr_wr & ~key_ok;
    wd_early = rcr_wr & key_ok & win_act &
               (wd_cnt_r < wd_open(tsel_r));
    illegal_address_reset = run & (reg_req.wr | reg_req.rd) &
           (reg_req.addr >= UNIMP_LO) &
           (reg_req.addr <= UNIMP_HI);
    wd_reset = wd_timeout | wd_badkey | wd_early;
    rst_req = (run & (wd_reset | illegal_address_reset | (illegal_opcode & ~wd_reset) |
               debug_force_reset)) | ext_hold;
    cause_nxt = 8'h00;
    if (wd_reset) begin
      cause_nxt[CAUSE_WDOG] = 1'b1;
    end else if (run) begin
      cause_nxt[CAUSE_ILLEGAL_OPCODE_RESET] = illegal_opcode;
      cause_nxt[CAUSE_ILLEGAL_ADDRESS_RESET] = illegal_address_reset;
    end
    cause_nxt[CAUSE_PIN] = pin_sync_r[1];
    cause_nxt[CAUSE_LVD] = lvd_sync_r[1];
  end

  // Reset sequencer: hold, fetch vector bytes, run
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_HOLD;
      hold_cnt_r <= 16'h0000;
    end else begin
      unique case (state_r)
        ST_HOLD: begin
          if (ext_hold) begin
            hold_cnt_r <= 16'h0000;
          end else if (hold_cnt_r == 16'(HOLD_CYC - 1)) begin
            state_r <= ST_FETCH_HI;
          end else begin
            hold_cnt_r <= hold_cnt_r + 16'h0001;
          end
        end
        ST_FETCH_HI: begin
          state_r <= ext_hold ? ST_HOLD : ST_FETCH_LO;
          hold_cnt_r <= 16'h0000;
        end
        ST_FETCH_LO: begin
          if (ext_hold) begin
            state_r <= ST_HOLD;
          end else if (fetch_lo_data_r) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (rst_req) begin
            state_r <= ST_HOLD;
            hold_cnt_r <= 16'h0000;
          end
        end
      endcase
    end
  end

  // Vector fetch strobes and program counter load
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      vec_rd <= 1'b0;
      vec_addr <= VEC_HI_ADDR;
      vec_hi_r <= 8'h00;
      pc_init <= 16'h0000;
      fetch_lo_data_r <= 1'b0;
    end else begin
      vec_rd <= 1'b0;
      fetch_lo_data_r <= 1'b0;
      if (state_r == ST_HOLD && !ext_hold &&
          hold_cnt_r == 16'(HOLD_CYC - 1)) begin
        vec_rd <= 1'b1;
        vec_addr <= VEC_HI_ADDR;
      end
      if (state_r == ST_FETCH_HI) begin
        vec_hi_r <= vec_rdata;
        vec_rd <= 1'b1;
        vec_addr <= VEC_LO_ADDR;
      end
      if (state_r == ST_FETCH_LO && !fetch_lo_data_r) begin
        fetch_lo_data_r <= 1'b1;
        pc_init <= {vec_hi_r, vec_rdata};
      end
    end
  end

  // Core-facing reset state: stack, mask, pins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stack_pointer <= SP_RESET;
      imask <= 1'b1;
      sys_reset_n <= 1'b0;
      cpu_run <= 1'b0;
      periph_disable <= 1'b1;
      pins_force_input <= 1'b1;
    end else begin
      if (state_r != ST_RUN || rst_req) begin
        stack_pointer <= SP_RESET;
        imask <= 1'b1;
        sys_reset_n <= 1'b0;
        cpu_run <= 1'b0;
        periph_disable <= 1'b1;
        pins_force_input <= 1'b1;
      end else begin
        if (imask_clear) begin
          imask <= 1'b0;
        end
        sys_reset_n <= 1'b1;
        cpu_run <= 1'b1;
        periph_disable <= 1'b0;
        pins_force_input <= 1'b0;
      end
    end
  end

  // Reset cause capture, read-only to software
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cause_r <= 8'h80;
    end else if (run && rst_req) begin
      cause_r <= cause_nxt;
    end else if (!run) begin
      cause_r <= cause_r | cause_nxt;
    end
  end

  // Divider making the 1 kHz low-power tick
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lpo_cnt_r <= 16'h0000;
      lpo_tick_r <= 1'b0;
    end else if (lpo_cnt_r == 16'(LPO_DIV - 1)) begin
      lpo_cnt_r <= 16'h0000;
      lpo_tick_r <= 1'b1;
    end else begin
      lpo_cnt_r <= lpo_cnt_r + 16'h0001;
      lpo_tick_r <= 1'b0;
    end
  end

  // Write-once watchdog options, defaults restored by reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tsel_r <= TSEL_RESET;
      clks_r <= CLKS_RESET;
      win_r <= WIN_RESET;
      opt1_lock_r <= 1'b0;
      opt2_lock_r <= 1'b0;
    end else if (!run) begin
      tsel_r <= TSEL_RESET;
      clks_r <= CLKS_RESET;
      win_r <= WIN_RESET;
      opt1_lock_r <= 1'b0;
      opt2_lock_r <= 1'b0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == SYSTEM_OPTIONS_ONE_ADDR && !opt1_lock_r) begin
        tsel_r <= reg_req.wdata[TSEL_POS +: 2];
        opt1_lock_r <= 1'b1;
      end
      if (reg_req.addr == SYSTEM_OPTIONS_TWO_ADDR && !opt2_lock_r) begin
        clks_r <= reg_req.wdata[CLKS_POS];
        win_r <= reg_req.wdata[WIN_POS];
        opt2_lock_r <= 1'b1;
      end
    end
  end

  // Watchdog counter with key sequence service
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wd_cnt_r <= 19'h0_0000;
      wd_armed_r <= 1'b0;
    end else if (!run || rst_req) begin
      wd_cnt_r <= 19'h0_0000;
      wd_armed_r <= 1'b0;
    end else begin
      if (rcr_wr && reg_req.wdata == KEY_FIRST) begin
        wd_armed_r <= 1'b1;
      end else if (rcr_wr && reg_req.wdata == KEY_SECOND) begin
        wd_armed_r <= 1'b0;
      end
      if (rcr_wr && reg_req.wdata == KEY_SECOND && wd_armed_r) begin
        wd_cnt_r <= 19'h0_0000;
      end else if (!clks_r && wd_freeze) begin
        wd_cnt_r <= 19'h0_0000;
      end else if (wd_inc) begin
        wd_cnt_r <= wd_cnt_r + 19'h0_0001;
      end
    end
  end

  // Register read data, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        RCR_ADDR: reg_rdata <= cause_r;
        SYSTEM_OPTIONS_ONE_ADDR: reg_rdata <= 8'(tsel_r) << TSEL_POS;
        SYSTEM_OPTIONS_TWO_ADDR: reg_rdata <= (8'(clks_r) << CLKS_POS) |
                                 (8'(win_r) << WIN_POS);
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

`default_nettype wire

/* File: reset_wdog_monitor.sv */
// Port assertions for the reset sequencer and watchdog
`timescale 1ns/10ps
`default_nettype none
module reset_wdog_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire wdog_pkg::reg_req_s reg_req,
  input wire logic illegal_opcode,
  input wire logic imask_clear,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  input wire logic [15:0] stack_pointer,
  input wire logic imask,
  input wire logic sys_reset_n,
  input wire logic cpu_run,
  input wire logic periph_disable,
  input wire logic pins_force_input
);
  import wdog_pkg::*;
  logic bad_key;
  logic unimp;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Request decode
  assign bad_key = reg_req.wr && reg_req.addr == RCR_ADDR &&
    reg_req.wdata != KEY_FIRST && reg_req.wdata != KEY_SECOND;
  assign unimp = (reg_req.wr || reg_req.rd) &&
    reg_req.addr >= UNIMP_LO && reg_req.addr <= UNIMP_HI;
  // Reset state values and interrupt mask release
  sp_reset_a: assert property (!sys_reset_n |-> stack_pointer == SP_RESET)
    else $error("stack pointer wrong in reset");
  imask_set_a: assert property (!sys_reset_n |-> imask)
    else $error("mask clear in reset");
  pins_float_a: assert property (!sys_reset_n |->
    periph_disable && pins_force_input) else $error("pins driven in reset");
  mask_clear_a: assert property ($fell(imask) |-> $past(imask_clear))
    else $error("mask fell without clear");
  // Reset sequence shape
  vec_order_a: assert property (vec_rd && vec_addr == VEC_HI_ADDR
    |=> vec_rd && vec_addr == VEC_LO_ADDR) else $error("vector order");
  reset_hold_a: assert property ($fell(sys_reset_n) |=>
    !sys_reset_n [*4]) else $error("reset too short");
  // Reset sources
  bad_key_a: assert property (cpu_run && bad_key |=> !sys_reset_n)
    else $error("bad key without reset");
  illegal_address_reset_hit_a: assert property (cpu_run && unimp |=> !sys_reset_n)
    else $error("unmapped access without reset");
  illegal_opcode_reset_hit_a: assert property (cpu_run && illegal_opcode |=>
    !sys_reset_n) else $error("bad opcode without reset");
  cover property (cpu_run && bad_key);
  cover property (cpu_run && unimp);
  cover property ($fell(sys_reset_n));
endmodule
bind reset_sources_and_watchdog reset_wdog_monitor mon (
  .clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req),
  .illegal_opcode(illegal_opcode), .imask_clear(imask_clear),
  .vec_rd(vec_rd), .vec_addr(vec_addr), .stack_pointer(stack_pointer),
  .imask(imask), .sys_reset_n(sys_reset_n), .cpu_run(cpu_run),
  .periph_disable(periph_disable), .pins_force_input(pins_force_input));
`default_nettype wire

/* File: core_mem_model.sv */
// Memory model answering the reset vector fetch
`timescale 1ns/10ps
`default_nettype none
module core_mem_model #(
  parameter logic [15:0] VEC = 16'h8000
) (
  input wire logic clk_sys,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  output logic [7:0] vec_rdata
);
  import wdog_pkg::*;
  // Byte stands while the strobe is high, as the fetch samples it then
  always_comb begin
    if (vec_rd) begin
      vec_rdata = (vec_addr == VEC_HI_ADDR) ? VEC[15:8] : VEC[7:0];
    end else begin
      vec_rdata = ~VEC[7:0];
    end
  end
endmodule
`default_nettype wire

/* File: reset_sources_and_watchdog_tb.sv */
// Self-checking bench for the reset and watchdog block
`timescale 1ns/10ps
`default_nettype none
module reset_sources_and_watchdog_tb;
  import wdog_pkg::*;
  localparam int DIV = 4;
  localparam logic [15:0] VEC = 16'hC35A;
  logic clk_sys = 0;
  logic nrst = 0;
  reg_req_s req = '0;
  logic illegal_opcode_reset = 0;
  logic dbg = 0;
  logic bdm = 0;
  logic iclr = 0;
  logic [7:0] rdata, vdata, d;
  logic [15:0] vaddr, pc, sp;
  logic vrd, im, srst_n, run, pdis, pin_in;
  int fail_count = 0;
  int checks = 0;
  int c, k, lim;
  int pos[4] = '{CAUSE_WDOG, CAUSE_ILLEGAL_ADDRESS_RESET, CAUSE_ILLEGAL_OPCODE_RESET, -1};
  always #10 clk_sys = ~clk_sys;
  reset_sources_and_watchdog #(.LPO_DIV(DIV), .HOLD_CYC(2)) uut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_req(req), .reg_rdata(rdata),
    .pin_reset_n(1'b1), .lvd_req(1'b0), .illegal_opcode(illegal_opcode_reset),
    .debug_force_reset(dbg), .bdm_mode(bdm), .stop_mode(1'b0),
    .imask_clear(iclr), .vec_rd(vrd), .vec_addr(vaddr),
    .vec_rdata(vdata), .pc_init(pc), .stack_pointer(sp), .imask(im),
    .sys_reset_n(srst_n), .cpu_run(run), .periph_disable(pdis),
    .pins_force_input(pin_in));
  core_mem_model #(.VEC(VEC)) core (.clk_sys(clk_sys), .vec_rd(vrd),
    .vec_addr(vaddr), .vec_rdata(vdata));
  // Expected cause byte and timeout length
  function automatic logic [7:0] cause(input int b);
    return b < 0 ? 8'h00 : 8'h01 << b;
  endfunction
  function automatic int limit(input logic ck, input logic [1:0] t);
    if (ck) return 1 << (t == 1 ? 13 : t == 2 ? 16 : 18);
    return (1 << (t == 1 ? 5 : t == 2 ? 8 : 10)) * DIV;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_rst(input int n);
    c = 0;
    while (srst_n !== 1'b0 && c < n) begin
      @(posedge clk_sys);
      #1 c++;
    end
  endtask
  task automatic boot();
    c = 0;
    while (run !== 1'b1 && c < 100) begin
      @(posedge clk_sys);
      #1 c++;
    end
    chk(run, 1'b1);
  endtask
  task automatic give_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #1_500_000;
    fail_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h5325_9a84));
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    boot();
    chk(pc, VEC);
    chk(sp, SP_RESET);
    chk(im, 1'b1);
    chk(pdis | pin_in, 1'b0);
    rd(RCR_ADDR);
    chk(d, cause(CAUSE_POR));
    rd(SYSTEM_OPTIONS_ONE_ADDR);
    chk(d, {TSEL_RESET, 6'h00});
    rd(SYSTEM_OPTIONS_TWO_ADDR);
    chk(d, {CLKS_RESET, WIN_RESET, 6'h00});
    @(posedge clk_sys);
    iclr <= 1'b1;
    @(posedge clk_sys);
    iclr <= 1'b0;
    #1 chk(im, 1'b0);
    // Slow clock, shortest timeout, locked options
    wr(SYSTEM_OPTIONS_ONE_ADDR, 8'h40);
    wr(SYSTEM_OPTIONS_ONE_ADDR, 8'hC0);
    wr(SYSTEM_OPTIONS_TWO_ADDR, 8'h40);
    wr(SYSTEM_OPTIONS_TWO_ADDR, 8'hC0);
    rd(SYSTEM_OPTIONS_ONE_ADDR);
    chk(d, 8'h40);
    rd(SYSTEM_OPTIONS_TWO_ADDR);
    chk(d, 8'h40);
    wr(RCR_ADDR, KEY_FIRST);
    wr(RCR_ADDR, KEY_SECOND);
    repeat (80) @(posedge clk_sys);
    bdm <= 1'b1;
    repeat (300) @(posedge clk_sys);
    chk(srst_n, 1'b1);
    bdm <= 1'b0;
    wait_rst(1000);
    lim = limit(1'b0, 2'h1);
    chk(c > lim - 2 * DIV && c <= lim + DIV, 1'b1);
    boot();
    rd(RCR_ADDR);
    chk(d, cause(CAUSE_WDOG));
    // Bus clock with regular service
    lim = limit(1'b1, 2'h1);
    wr(SYSTEM_OPTIONS_ONE_ADDR, 8'h40);
    wr(SYSTEM_OPTIONS_TWO_ADDR, 8'h80);
    for (int i = 0; i < 3; i++) begin
      repeat (lim - 300) @(posedge clk_sys);
      wr(RCR_ADDR, KEY_FIRST);
      wr(RCR_ADDR, KEY_SECOND);
    end
    chk(srst_n, 1'b1);
    rd(RCR_ADDR);
    chk(d, cause(CAUSE_WDOG));
    wait_rst(lim + 100);
    chk(c > lim - 16 && c <= lim + 2, 1'b1);
    // Windowed service, early then inside the window
    for (int i = 0; i < 2; i++) begin
      boot();
      wr(SYSTEM_OPTIONS_ONE_ADDR, 8'h40);
      wr(SYSTEM_OPTIONS_TWO_ADDR, 8'hC0);
      repeat (lim / 4 * 3 + (i == 0 ? -200 : 100)) @(posedge clk_sys);
      wr(RCR_ADDR, KEY_FIRST);
      wr(RCR_ADDR, KEY_SECOND);
      chk(srst_n, i == 0 ? 1'b0 : 1'b1);
    end
    // Disabled watchdog outlives the default timeout
    wr(RCR_ADDR, 8'h00);
    wait_rst(3);
    chk(srst_n, 1'b0);
    boot();
    wr(SYSTEM_OPTIONS_ONE_ADDR, 8'h00);
    repeat (limit(1'b0, 2'h3) + 500) @(posedge clk_sys);
    chk(srst_n, 1'b1);
    // Random and corner reset sources
    for (int i = 0; i < 8; i++) begin
      k = i < 4 ? i : $urandom % 4;
      d = 8'($urandom);
      if (d == KEY_FIRST || d == KEY_SECOND) d = 8'h00;
      if (k == 0) wr(RCR_ADDR, d);
      if (k == 1) rd(i == 1 ? UNIMP_HI : UNIMP_LO + $urandom % 16'h6700);
      if (k > 1) begin
        @(posedge clk_sys);
        illegal_opcode_reset <= k == 2;
        dbg <= k == 3;
        @(posedge clk_sys);
        illegal_opcode_reset <= 1'b0;
        dbg <= 1'b0;
      end
      wait_rst(3);
      chk(srst_n, 1'b0);
      boot();
      rd(RCR_ADDR);
      chk(d, cause(pos[k]));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
